// ===== design/ior_pkg.sv
package ior_pkg;

  // Register byte addresses, one 16-bit word each
  localparam logic [7:0] RATE_X_LOW_OFS = 8'h04;
  localparam logic [7:0] RATE_X_HIGH_OFS = 8'h06;
  localparam logic [7:0] RATE_Y_LOW_OFS = 8'h08;
  localparam logic [7:0] RATE_Y_HIGH_OFS = 8'h0A;
  localparam logic [7:0] RATE_Z_LOW_OFS = 8'h0C;
  localparam logic [7:0] RATE_Z_HIGH_OFS = 8'h0E;
  localparam logic [7:0] ACCEL_X_LOW_OFS = 8'h10;
  localparam logic [7:0] ACCEL_X_HIGH_OFS = 8'h12;
  localparam logic [7:0] ACCEL_Y_LOW_OFS = 8'h14;
  localparam logic [7:0] ACCEL_Y_HIGH_OFS = 8'h16;
  localparam logic [7:0] ACCEL_Z_LOW_OFS = 8'h18;
  localparam logic [7:0] ACCEL_Z_HIGH_OFS = 8'h1A;
  // Control register of our own: bit 0 freezes sample capture
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam int CTRL_FREEZE_BIT = 0;
  // Status register of our own: bit 0 data valid, [15:8] update count
  localparam logic [7:0] STAT_OFS = 8'h42;
  localparam int STAT_VALID_BIT = 0;

  // Reset values (data have no documented default; zero is used)
  localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [15:0] UNMAPPED_RDATA = 16'h0000;

  // Scale factors, counts per degree per second, by range model
  localparam int RATE_SCALE_SMALL = 160;
  localparam int RATE_SCALE_MID = 40;
  localparam int RATE_SCALE_LARGE = 10;
  // Acceleration: micro-g per high-word count, full span in g
  localparam int ACCEL_UG_PER_COUNT = 1250;
  localparam int ACCEL_SPAN_G = 40;

  // One full sample set, all six axes in one common frame
  typedef struct packed {
    logic [31:0] rate_x;
    logic [31:0] rate_y;
    logic [31:0] rate_z;
    logic [31:0] accel_x;
    logic [31:0] accel_y;
    logic [31:0] accel_z;
  } ior_sample_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ior_req_t;

endpackage

// ===== design/ior_regs.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - Rate high word: twos complement, zero is zero
// - Low word carries sixteen extra resolution bits
// - High and low words form one 32-bit value
// - Accel high word: 1.25 mg/count, 40 g
// - Rate x low 0x04, high 0x06, read-only
// - Rate y low 0x08, high 0x0A, read-only
// - Rate z low 0x0C, high 0x0E, read-only
// - Accel x low 0x10, high 0x12, read-only
// - Accel y low 0x14, high 0x16, read-only
// - Accel z low word at 0x18, read-only
// - Accel and rate axes share one frame
// - Rate scale 160, 40 or 10 per dps
// - Accel z high word at 0x1A, read-only
module ior_regs (
  input wire logic clk, // 25 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire ior_pkg::ior_sample_t sample_in, // New sample set, same clock
  input wire logic sample_stb, // One-cycle pulse: sample_in valid
  input wire ior_pkg::ior_req_t req, // Register port request
  output logic [15:0] rdata, // Read data, cycle after read strobe
  output logic data_valid // Sample captured since reset
);

  // All state of the bank in one record
  typedef struct packed {
    ior_pkg::ior_sample_t smp;
    logic freeze;
    logic valid;
    logic [7:0] cnt;
    logic [15:0] rdata;
  } ior_state_t;

  ior_state_t st_r;
  ior_state_t st_nxt;

  // Word select for one axis: high half or low half of 32 bits
  function automatic logic [15:0] half_word(input logic [31:0] v,
                                            input logic hi);
    half_word = hi ? v[31:16] : v[15:0];
  endfunction

  // Next state: capture, control write and read mux
  always_comb begin
    st_nxt = st_r;
    // Whole 32-bit set loads at once, so a host reading low then
    // high between updates sees one coherent value
    if (sample_stb && !st_r.freeze) begin
      st_nxt.smp = sample_in;
      st_nxt.valid = 1'b1;
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
    // Only the control word is writable; data words ignore writes
    if (req.wr && req.addr == ior_pkg::CTRL_OFS) begin
      st_nxt.freeze = req.wdata[ior_pkg::CTRL_FREEZE_BIT];
    end
    st_nxt.rdata = st_r.rdata;
    if (req.rd) begin
      // Data passes through untouched: encoding and scale are those
      // of the producer, so 0 reads as 0 and counts keep their LSB
      case (req.addr)
        ior_pkg::RATE_X_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_x, 1'b0);
        end
        ior_pkg::RATE_X_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_x, 1'b1);
        end
        ior_pkg::RATE_Y_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_y, 1'b0);
        end
        ior_pkg::RATE_Y_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_y, 1'b1);
        end
        ior_pkg::RATE_Z_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_z, 1'b0);
        end
        ior_pkg::RATE_Z_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.rate_z, 1'b1);
        end
        ior_pkg::ACCEL_X_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_x, 1'b0);
        end
        ior_pkg::ACCEL_X_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_x, 1'b1);
        end
        ior_pkg::ACCEL_Y_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_y, 1'b0);
        end
        ior_pkg::ACCEL_Y_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_y, 1'b1);
        end
        ior_pkg::ACCEL_Z_LOW_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_z, 1'b0);
        end
        ior_pkg::ACCEL_Z_HIGH_OFS: begin
          st_nxt.rdata = half_word(st_r.smp.accel_z, 1'b1);
        end
        ior_pkg::CTRL_OFS: begin
          st_nxt.rdata = {15'h0000, st_r.freeze};
        end
        ior_pkg::STAT_OFS: begin
          st_nxt.rdata = {st_r.cnt, 7'h00, st_r.valid};
        end
        default: begin
          st_nxt.rdata = ior_pkg::UNMAPPED_RDATA;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r.smp <= {6{ior_pkg::SAMPLE_RST}};
      st_r.freeze <= 1'b0;
      st_r.valid <= 1'b0;
      st_r.cnt <= 8'h00;
      st_r.rdata <= ior_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign data_valid = st_r.valid;

  // Word addresses the bank answers; all others read as unmapped
  function automatic logic word_mapped(input logic [7:0] a);
    case (a)
      ior_pkg::RATE_X_LOW_OFS, ior_pkg::RATE_X_HIGH_OFS,
      ior_pkg::RATE_Y_LOW_OFS, ior_pkg::RATE_Y_HIGH_OFS,
      ior_pkg::RATE_Z_LOW_OFS, ior_pkg::RATE_Z_HIGH_OFS,
      ior_pkg::ACCEL_X_LOW_OFS, ior_pkg::ACCEL_X_HIGH_OFS,
      ior_pkg::ACCEL_Y_LOW_OFS, ior_pkg::ACCEL_Y_HIGH_OFS,
      ior_pkg::ACCEL_Z_LOW_OFS, ior_pkg::ACCEL_Z_HIGH_OFS,
      ior_pkg::CTRL_OFS, ior_pkg::STAT_OFS: begin
        word_mapped = 1'b1;
      end
      default: begin
        word_mapped = 1'b0;
      end
    endcase
  endfunction

  // Read data follow a read of each data word by one cycle
  rate_x_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_X_HIGH_OFS
    |=> rdata == $past(st_r.smp.rate_x[31:16]))
    else $error("rate x high word wrong");

  rate_x_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_X_LOW_OFS
    |=> rdata == $past(st_r.smp.rate_x[15:0]))
    else $error("rate x low word wrong");

  rate_y_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_Y_HIGH_OFS
    |=> rdata == $past(st_r.smp.rate_y[31:16]))
    else $error("rate y high word wrong");

  rate_y_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_Y_LOW_OFS
    |=> rdata == $past(st_r.smp.rate_y[15:0]))
    else $error("rate y low word wrong");

  rate_z_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_Z_LOW_OFS
    |=> rdata == $past(st_r.smp.rate_z[15:0]))
    else $error("rate z low word wrong");

  rate_z_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::RATE_Z_HIGH_OFS
    |=> rdata == $past(st_r.smp.rate_z[31:16]))
    else $error("rate z high word wrong");

  accel_x_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_X_HIGH_OFS
    |=> rdata == $past(st_r.smp.accel_x[31:16]))
    else $error("accel x high word wrong");

  accel_x_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_X_LOW_OFS
    |=> rdata == $past(st_r.smp.accel_x[15:0]))
    else $error("accel x low word wrong");

  accel_y_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_Y_LOW_OFS
    |=> rdata == $past(st_r.smp.accel_y[15:0]))
    else $error("accel y low word wrong");

  accel_y_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_Y_HIGH_OFS
    |=> rdata == $past(st_r.smp.accel_y[31:16]))
    else $error("accel y high word wrong");

  accel_z_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_Z_LOW_OFS
    |=> rdata == $past(st_r.smp.accel_z[15:0]))
    else $error("accel z low word wrong");

  accel_z_high_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::ACCEL_Z_HIGH_OFS
    |=> rdata == $past(st_r.smp.accel_z[31:16]))
    else $error("accel z high word wrong");

  // Own registers and the unmapped space
  ctrl_read_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::CTRL_OFS
    |=> rdata == {15'h0000, $past(st_r.freeze)})
    else $error("control read wrong");

  stat_read_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && req.addr == ior_pkg::STAT_OFS
    |=> rdata == {$past(st_r.cnt), 7'h00, $past(st_r.valid)})
    else $error("status read wrong");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.rd && !word_mapped(req.addr)
    |=> rdata == ior_pkg::UNMAPPED_RDATA)
    else $error("unmapped read not blank");

  // Read data stand until the next read strobe
  rdata_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !req.rd
    |=> $stable(rdata))
    else $error("read data moved without read");

  // A strobe while not frozen loads all six axes whole, one cycle on
  sample_load_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_stb && !st_r.freeze
    |=> st_r.smp == $past(sample_in) && data_valid)
    else $error("sample set not loaded whole");

  // A low word read just after a load already shows the new sample
  fresh_low_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_stb && !st_r.freeze ##1 !sample_stb
    ##1 req.rd && req.addr == ior_pkg::RATE_X_LOW_OFS
    |=> rdata == $past(sample_in.rate_x[15:0], 3))
    else $error("low word stale after load");

  // Data words ignore writes
  data_ro_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !sample_stb
    |=> $stable(st_r.smp))
    else $error("data word changed without sample");

  // Freeze keeps every word, so a slow host still reads pairs whole
  frozen_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    st_r.freeze
    |=> $stable(st_r.smp))
    else $error("data word changed while frozen");

  freeze_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    req.wr && req.addr == ior_pkg::CTRL_OFS
    |=> st_r.freeze == $past(req.wdata[ior_pkg::CTRL_FREEZE_BIT]))
    else $error("freeze write not taken");

  ctrl_only_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !(req.wr && req.addr == ior_pkg::CTRL_OFS)
    |=> $stable(st_r.freeze))
    else $error("freeze moved without control write");

  // Update count steps once per accepted sample, and only then
  count_step_a: assert property (
    @(posedge clk) disable iff (!rstn)
    sample_stb && !st_r.freeze
    |=> st_r.cnt == $past(st_r.cnt) + 8'h01)
    else $error("update count did not step");

  count_still_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !(sample_stb && !st_r.freeze)
    |=> $stable(st_r.cnt))
    else $error("update count moved without sample");

  // Valid only falls by reset
  valid_sticky_a: assert property (
    @(posedge clk) disable iff (!rstn)
    data_valid
    |=> data_valid)
    else $error("data valid fell");

endmodule

// ===== verification/ior_host.sv
`timescale 1ns/1ps
// Host on the register port; each call makes one request
module ior_host (
  input wire logic clk, // Bench clock
  input wire logic [15:0] rdata, // Read data from the bank
  output ior_pkg::ior_req_t req // Request toward the bank
);
  initial req = '0;
  // Write: one strobe cycle beside address and data
  task automatic wr16(input logic [7:0] a, input logic [15:0] wd);
    @(posedge clk);
    req <= '{addr: a, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask
  // Read: data appear in the cycle after the strobe and stand until the next read
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk;
  logic rstn;
  logic sample_stb;
  logic data_valid;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [31:0] v [6];
  ior_pkg::ior_sample_t smp;
  ior_pkg::ior_req_t req;
  int n_fail;
  int n_checks;
  // Low word offset per axis; the high word sits two bytes above
  logic [7:0] lo [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};

  ior_regs dut_u (.clk(clk), .rstn(rstn), .sample_in(smp),
    .sample_stb(sample_stb), .req(req), .rdata(rdata),
    .data_valid(data_valid));
  ior_host host_u (.clk(clk), .rdata(rdata), .req(req));

  // Sample strobe; inverted set checks that nothing stale survives
  task automatic load(input bit inv);
    @(posedge clk);
    smp <= inv ? ~{v[0], v[1], v[2], v[3], v[4], v[5]}
               : {v[0], v[1], v[2], v[3], v[4], v[5]};
    sample_stb <= 1'b1;
    @(posedge clk);
    sample_stb <= 1'b0;
    // Let the capture edge settle before callers look
    #1;
  endtask
  // Every low and high word against the expected sample set
  task automatic check_all;
    for (int a = 0; a < 6; a++) begin
      host_u.rd16(lo[a], d);
      `CHK("low word", v[a][15:0], d)
      host_u.rd16(lo[a] + 8'h02, d);
      `CHK("high word", v[a][31:16], d)
    end
  endtask
  task automatic t_reset;
    `CHK("valid", 1'b0, data_valid)
    host_u.rd16(8'h06, d);
    `CHK("reset word", 16'h0000, d)
    $display("test reset done");
  endtask
  // Boundary codes of both encodings, then a refused write
  task automatic t_map;
    v = '{32'h4E20_0001, 32'hB1E0_FFFF, 32'h0000_8000,
          32'h7D00_0002, 32'h8300_FFFE, 32'hFFFF_FFFF};
    load(0);
    `CHK("valid", 1'b1, data_valid)
    check_all();
    host_u.wr16(8'h12, 16'h1234);
    host_u.rd16(8'h12, d);
    `CHK("read only", 16'h7D00, d)
    host_u.rd16(8'h20, d);
    `CHK("unmapped", 16'h0000, d)
    $display("test map done");
  endtask
  // Frozen capture keeps old words; release loads both halves
  task automatic t_freeze;
    host_u.wr16(8'h40, 16'h0001);
    host_u.rd16(8'h40, d);
    `CHK("control", 16'h0001, d)
    load(1);
    check_all();
    host_u.wr16(8'h40, 16'h0000);
    load(1);
    for (int k = 0; k < 6; k++) v[k] = ~v[k];
    check_all();
    host_u.rd16(8'h42, d);
    `CHK("status", 16'h0201, d)
    $display("test freeze done");
  endtask
  // Reset in mid-run clears capture, count and data words
  task automatic t_rerun;
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    `CHK("valid", 1'b0, data_valid)
    rstn <= 1'b1;
    host_u.rd16(8'h42, d);
    `CHK("status", 16'h0000, d)
    host_u.rd16(8'h12, d);
    `CHK("reset word", 16'h0000, d)
    $display("test rerun done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Free-running clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Tests need about 120 cycles; 5000 means a hang
  initial begin
    #200000;
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    sample_stb = 1'b0;
    smp = '0;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_map();
    t_freeze();
    t_rerun();
    results();
  end
endmodule
